// ==== logic/usr_map.svh ====
// register map, field positions and reset values of the universal shift register
`ifndef USR_MAP_SVH
`define USR_MAP_SVH

`define USR_WIDTH        4
`define USR_ADDR_W       12
`define USR_DATA_W       32
`define USR_OFS_CTRL     12'h000
`define USR_OFS_STATUS   12'h004
`define USR_CTRL_SRC     0
`define USR_CTRL_MODE_LO 1
`define USR_CTRL_MODE_HI 2
`define USR_CTRL_RIGHT   3
`define USR_CTRL_LEFT    4
`define USR_CTRL_PAR_LSB 8
`define USR_CTRL_PAR_MSB 11
`define USR_STAT_SRC     8
`define USR_CTRL_RST     32'h0000_0000
`define USR_STAGES_RST   4'h0
`define USR_RDATA_RST    32'h0000_0000

`endif

// ==== logic/usr_pkg.sv ====
// types shared by the universal shift register
`default_nettype none
`include "usr_map.svh"

package usr_pkg;

  // order follows {high select, low select}
  typedef enum logic [1:0] {
    USR_HOLD,
    USR_SHIFT_RIGHT,
    USR_SHIFT_LEFT,
    USR_LOAD
  } usr_mode_t;

  typedef struct packed {
    usr_mode_t                mode;
    logic                     right_in;
    logic                     left_in;
    logic [`USR_WIDTH-1:0]    par;
  } usr_in_t;

endpackage : usr_pkg
`default_nettype wire

// ==== logic/usr_shift_register.sv ====
// four-bit universal shift register with pin and APB control
//
// Behaviour
// - four stages, stage 0 first, stage 3 last, each driving its own output
// - inputs sampled and contents changed only at rising clock edge, except by clear
// - two mode selects choose hold, shift right, shift left or parallel load
// - both selects high: parallel inputs copied into stages 0 to 3
// - clear low forces all stages low at once, without a clock edge
// - both selects low: all stages keep their value, clock may run
// - low select only: right serial into stage 0, others move up
// - high select only: stages move down, left serial into stage 3
// - serial inputs used only when shifting, ignored in hold and load
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "usr_map.svh"

module usr_shift_register (
  input  wire logic                    CLOCK,
  input  wire logic                    RST_N,
  input  wire logic                    ASYNC_CLEAR_N,
  input  wire logic                    MODE_SELECT_LOW_BIT,
  input  wire logic                    MODE_SELECT_HIGH_BIT,
  input  wire logic                    RIGHT_SHIFT_SERIAL_IN,
  input  wire logic                    LEFT_SHIFT_SERIAL_IN,
  input  wire logic [`USR_WIDTH-1:0]   PARALLEL_LOAD_INPUTS,
  output var  logic [`USR_WIDTH-1:0]   STAGE_OUTPUTS,
  output var  logic                    FIRST_STAGE_OUTPUT,
  output var  logic                    LAST_STAGE_OUTPUT,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [`USR_ADDR_W-1:0]  PADDR,
  input  wire logic [`USR_DATA_W-1:0]  PWDATA,
  output var  logic [`USR_DATA_W-1:0]  PRDATA,
  output var  logic                    PREADY,
  output var  logic                    PSLVERR
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [`USR_WIDTH-1:0]  stage_q;
  logic [`USR_WIDTH-1:0]  stage_d;
  logic [`USR_DATA_W-1:0] ctrl_q;
  logic [`USR_DATA_W-1:0] prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   apb_setup;
  logic                   apb_done;
  logic [`USR_DATA_W-1:0] rd_value;
  usr_pkg::usr_in_t       pin_in;
  usr_pkg::usr_in_t       reg_in;
  usr_pkg::usr_in_t       sel_in;

  // 0 = unmapped, 1 = control, 2 = status
  function automatic logic [1:0] usr_decode(input logic [`USR_ADDR_W-1:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    if (addr == `USR_OFS_CTRL)
    begin
      hit = 2'h1;
    end
    else if (addr == `USR_OFS_STATUS)
    begin
      hit = 2'h2;
    end
    return hit;
  endfunction : usr_decode

  // ----------------------------------------------------------------
  // input source selection
  // ----------------------------------------------------------------
  // pins come from logic on this same clock, so no synchroniser
  always_comb
  begin
    pin_in.mode     = usr_pkg::usr_mode_t'({MODE_SELECT_HIGH_BIT, MODE_SELECT_LOW_BIT});
    pin_in.right_in = RIGHT_SHIFT_SERIAL_IN;
    pin_in.left_in  = LEFT_SHIFT_SERIAL_IN;
    pin_in.par      = PARALLEL_LOAD_INPUTS;
    reg_in.mode     = usr_pkg::usr_mode_t'({ctrl_q[`USR_CTRL_MODE_HI], ctrl_q[`USR_CTRL_MODE_LO]});
    reg_in.right_in = ctrl_q[`USR_CTRL_RIGHT];
    reg_in.left_in  = ctrl_q[`USR_CTRL_LEFT];
    reg_in.par      = ctrl_q[`USR_CTRL_PAR_MSB:`USR_CTRL_PAR_LSB];
    sel_in          = ctrl_q[`USR_CTRL_SRC] ? reg_in : pin_in;
  end

  // ----------------------------------------------------------------
  // next stage value
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (sel_in.mode)
      usr_pkg::USR_HOLD:        stage_d = stage_q;
      usr_pkg::USR_SHIFT_RIGHT: stage_d = {stage_q[`USR_WIDTH-2:0], sel_in.right_in};
      usr_pkg::USR_SHIFT_LEFT:  stage_d = {sel_in.left_in, stage_q[`USR_WIDTH-1:1]};
      usr_pkg::USR_LOAD:        stage_d = sel_in.par;
    endcase
  end

  // ----------------------------------------------------------------
  // stage register
  // ----------------------------------------------------------------
  // clear acts without the clock; release leaves zero until the next edge
  always_ff @(posedge CLOCK or negedge ASYNC_CLEAR_N)
  begin
    if (!ASYNC_CLEAR_N)
    begin
      stage_q <= `USR_STAGES_RST;
    end
    else if (!RST_N)
    begin
      stage_q <= `USR_STAGES_RST;
    end
    else
    begin
      stage_q <= stage_d;
    end
  end

  assign STAGE_OUTPUTS      = stage_q;
  assign FIRST_STAGE_OUTPUT = stage_q[0];
  assign LAST_STAGE_OUTPUT  = stage_q[`USR_WIDTH-1];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign apb_setup = PSEL && !PENABLE;
  assign apb_done  = PSEL && PENABLE && pready_q;

  always_comb
  begin
    rd_value = '0;
    unique case (usr_decode(PADDR))
      2'h1:    rd_value = ctrl_q;
      2'h2:
      begin
        rd_value[`USR_WIDTH-1:0] = stage_q;
        rd_value[`USR_STAT_SRC]  = ctrl_q[`USR_CTRL_SRC];
      end
      default: rd_value = '0;
    endcase
  end

  // one wait-free access phase: ready rises in the cycle after setup
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `USR_RDATA_RST;
    end
    else
    begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && (usr_decode(PADDR) == 2'h0);
      prdata_q  <= (apb_setup && !PWRITE) ? rd_value : `USR_RDATA_RST;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ctrl_q <= `USR_CTRL_RST;
    end
    else if (apb_done && PWRITE && usr_decode(PADDR) == 2'h1)
    begin
      ctrl_q <= PWDATA;
    end
  end

  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA  = prdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_hold;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (sel_in.mode == usr_pkg::USR_HOLD) [*2] |=> (stage_q == $past(stage_q, 2));
  endproperty
  a_hold: assert property (p_hold) else $error("hold mode changed the stages");

  property p_shift_right;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (sel_in.mode == usr_pkg::USR_SHIFT_RIGHT)
      |=> (stage_q == {$past(stage_q[`USR_WIDTH-2:0]), $past(sel_in.right_in)});
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("shift right wrong");

  property p_shift_left;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (sel_in.mode == usr_pkg::USR_SHIFT_LEFT)
      |=> (stage_q == {$past(sel_in.left_in), $past(stage_q[`USR_WIDTH-1:1])});
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("shift left wrong");

  property p_load;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (sel_in.mode == usr_pkg::USR_LOAD) |=> (stage_q == $past(sel_in.par));
  endproperty
  a_load: assert property (p_load) else $error("parallel load wrong");

  property p_clear;
    @(posedge CLOCK) disable iff (!RST_N)
    !ASYNC_CLEAR_N |-> (stage_q == `USR_STAGES_RST);
  endproperty
  a_clear: assert property (p_clear) else $error("stages not low under clear");

  property p_release;
    @(posedge CLOCK) disable iff (!RST_N)
    $rose(ASYNC_CLEAR_N) |-> (stage_q == `USR_STAGES_RST);
  endproperty
  a_release: assert property (p_release) else $error("stages not zero at release");

  property p_serial_ignored;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (sel_in.mode == usr_pkg::USR_HOLD || sel_in.mode == usr_pkg::USR_LOAD)
      |=> (stage_q == (($past(sel_in.mode) == usr_pkg::USR_LOAD) ?
                       $past(sel_in.par) : $past(stage_q)));
  endproperty
  a_serial_ignored: assert property (p_serial_ignored) else $error("serial input leaked");

  property p_change_cause;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    ($changed(stage_q) && $past(RST_N) && $past(ASYNC_CLEAR_N))
      |-> ($past(sel_in.mode) != usr_pkg::USR_HOLD);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("stages changed in hold");

  property p_outputs;
    @(posedge CLOCK) disable iff (!RST_N)
    (STAGE_OUTPUTS == stage_q) && (FIRST_STAGE_OUTPUT == STAGE_OUTPUTS[0])
      && (LAST_STAGE_OUTPUT == STAGE_OUTPUTS[`USR_WIDTH-1]);
  endproperty
  a_outputs: assert property (p_outputs) else $error("stage outputs mismatch");

  // pin-level checks, independent of the internal source mux
  property p_mode_from_pins;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (!ctrl_q[`USR_CTRL_SRC] && !MODE_SELECT_HIGH_BIT && MODE_SELECT_LOW_BIT)
      |=> (stage_q == {$past(stage_q[`USR_WIDTH-2:0]), $past(RIGHT_SHIFT_SERIAL_IN)});
  endproperty
  a_mode_from_pins: assert property (p_mode_from_pins) else $error("pin shift right wrong");

  property p_pins_left;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (!ctrl_q[`USR_CTRL_SRC] && MODE_SELECT_HIGH_BIT && !MODE_SELECT_LOW_BIT)
      |=> (stage_q == {$past(LEFT_SHIFT_SERIAL_IN), $past(stage_q[`USR_WIDTH-1:1])});
  endproperty
  a_pins_left: assert property (p_pins_left) else $error("pin shift left wrong");

  property p_pins_load;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (!ctrl_q[`USR_CTRL_SRC] && MODE_SELECT_HIGH_BIT && MODE_SELECT_LOW_BIT)
      |=> (stage_q == $past(PARALLEL_LOAD_INPUTS));
  endproperty
  a_pins_load: assert property (p_pins_load) else $error("pin parallel load wrong");

  property p_pins_hold;
    @(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    (!ctrl_q[`USR_CTRL_SRC] && !MODE_SELECT_HIGH_BIT && !MODE_SELECT_LOW_BIT)
      |=> $stable(stage_q);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pin hold changed the stages");

  // ----------------------------------------------------------------
  // apb and reset assertions
  // ----------------------------------------------------------------
  property p_sync_reset;
    @(posedge CLOCK)
    !RST_N |=> (stage_q == `USR_STAGES_RST) && !PREADY && !PSLVERR;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset left state");

  property p_ready_after_setup;
    @(posedge CLOCK) disable iff (!RST_N)
    (PSEL && !PENABLE) |=> PREADY;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");

  property p_ready_one_cycle;
    @(posedge CLOCK) disable iff (!RST_N)
    PREADY |=> !PREADY;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("ready held too long");

  property p_err_with_ready;
    @(posedge CLOCK) disable iff (!RST_N)
    PSLVERR |-> PREADY;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_rdata_idle;
    @(posedge CLOCK) disable iff (!RST_N)
    !PREADY |-> (PRDATA == `USR_RDATA_RST);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");

  property p_ctrl_write;
    @(posedge CLOCK) disable iff (!RST_N)
    (PSEL && PENABLE && PREADY && PWRITE && (PADDR == `USR_OFS_CTRL))
      |=> (ctrl_q == $past(PWDATA));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_status_read;
    @(posedge CLOCK) disable iff (!RST_N)
    (PSEL && !PENABLE && !PWRITE && (PADDR == `USR_OFS_STATUS))
      |=> (PRDATA[`USR_WIDTH-1:0] == $past(stage_q));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  c_load_then_right: cover property (@(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    sel_in.mode == usr_pkg::USR_LOAD ##1 sel_in.mode == usr_pkg::USR_SHIFT_RIGHT [*3]);
  c_shift_left_run: cover property (@(posedge CLOCK) disable iff (!RST_N || !ASYNC_CLEAR_N)
    sel_in.mode == usr_pkg::USR_SHIFT_LEFT [*4]);
  c_clear_release: cover property (@(posedge CLOCK) disable iff (!RST_N)
    $rose(ASYNC_CLEAR_N));
  c_sw_source: cover property (@(posedge CLOCK) disable iff (!RST_N)
    ctrl_q[`USR_CTRL_SRC] && sel_in.mode == usr_pkg::USR_LOAD);

endmodule : usr_shift_register
`default_nettype wire

// ==== bench/usr_far_logic.sv ====
// far-side logic model driving the mode and data pins
`timescale 1ns/10ps
`default_nettype none
module usr_far_logic (
  input  wire logic             CLOCK,
  input  wire usr_pkg::usr_in_t cmd,
  output var  logic             mode_lo = 1'b0,
  output var  logic             mode_hi = 1'b0,
  output var  logic             right_in = 1'b0,
  output var  logic             left_in = 1'b0,
  output var  logic [3:0]       par = 4'h0
);
  // pins move just after the rising edge, so they are stable at the next one
  always @(posedge CLOCK)
  begin
    {mode_hi, mode_lo} <= cmd.mode;
    right_in           <= cmd.right_in;
    left_in            <= cmd.left_in;
    par                <= cmd.par;
  end
endmodule : usr_far_logic
`default_nettype wire

// ==== bench/usr_shift_register_bench.sv ====
// self-checking bench of the universal shift register
`timescale 1ns/10ps
`default_nettype none
module usr_shift_register_bench;
  logic              CLOCK = 1'b0;
  logic              RST_N = 1'b0;
  logic              clr_n = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata, rd, ctl_m = 32'h0;
  logic              pready, pslverr, er, m_lo, m_hi, r_in, l_in, q0, q3;
  logic [3:0]        par, q, exp_q = 4'h0;
  usr_pkg::usr_in_t  cmd = '0;
  int                err_total = 0, n_checks = 0, cyc = 0;
  logic [7:0]        tbl [9] = '{8'hFA, 8'h6F, 8'h6F, 8'h40, 8'h90, 8'hAF, 8'h3F, 8'hC5, 8'h00};

  initial forever #12.5 CLOCK = ~CLOCK;

  usr_far_logic far (.CLOCK(CLOCK), .cmd(cmd), .mode_lo(m_lo), .mode_hi(m_hi),
    .right_in(r_in), .left_in(l_in), .par(par));

  usr_shift_register dut (.CLOCK(CLOCK), .RST_N(RST_N), .ASYNC_CLEAR_N(clr_n),
    .MODE_SELECT_LOW_BIT(m_lo), .MODE_SELECT_HIGH_BIT(m_hi), .RIGHT_SHIFT_SERIAL_IN(r_in),
    .LEFT_SHIFT_SERIAL_IN(l_in), .PARALLEL_LOAD_INPUTS(par), .STAGE_OUTPUTS(q),
    .FIRST_STAGE_OUTPUT(q0), .LAST_STAGE_OUTPUT(q3), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr));

  // ----------------------------------------
  // reference model and checks
  // ----------------------------------------
  function automatic logic [3:0] nxt(logic [1:0] m, logic r, logic l, logic [3:0] p,
                                     logic [3:0] s);
    case (m)
      2'h0: nxt = s;
      2'h1: nxt = {s[2:0], r};
      2'h2: nxt = {l, s[3:1]};
      default: nxt = p;
    endcase
  endfunction : nxt

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  always @(posedge CLOCK or negedge clr_n)
    if (!clr_n || !RST_N)
      exp_q <= 4'h0;
    else if (ctl_m[0])
      exp_q <= nxt(ctl_m[2:1], ctl_m[3], ctl_m[4], ctl_m[11:8], exp_q);
    else
      exp_q <= nxt({m_hi, m_lo}, r_in, l_in, par, exp_q);

  always @(negedge CLOCK)
  begin
    cmp("stages", {28'h0, exp_q}, {28'h0, q});
    cmp("ends", {30'h0, exp_q[3], exp_q[0]}, {30'h0, q3, q0});
  end

  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      err_total++;
      summarize();
    end
  end

  // ----------------------------------------
  // apb master and main sequence
  // ----------------------------------------
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge CLOCK);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge CLOCK);
    penable <= 1'b1;
    do
    begin
      @(posedge CLOCK);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    if (w && a == 12'h000)
      ctl_m <= d;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  initial
  begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp("ctrl_rst", 32'h0, rd);
    for (int p = 0; p < 2; p++)
      foreach (tbl[i])
      begin
        @(posedge CLOCK);
        cmd <= usr_pkg::usr_in_t'(tbl[i]);
      end
    @(posedge CLOCK);
    cmd <= usr_pkg::usr_in_t'(8'hF5);
    clr_n <= 1'b0;
    repeat (3) @(posedge CLOCK);
    clr_n <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLOCK);
    RST_N <= 1'b1;
    cmd <= usr_pkg::usr_in_t'(8'h3F);
    apb(1'b1, 12'h000, 32'h0000_0B07);
    apb(1'b0, 12'h004, 32'h0);
    cmp("status", 32'h0000_010B, rd);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    cmp("ro_err", 32'h0, {31'h0, er});
    apb(1'b0, 12'h000, 32'h0);
    cmp("ctrl", 32'h0000_0B07, rd);
    apb(1'b1, 12'h008, 32'h1);
    cmp("bad_w", 32'h1, {31'h0, er});
    apb(1'b0, 12'h008, 32'h0);
    cmp("bad_r", 32'h1, {31'h0, er});
    cmp("bad_rd", 32'h0, rd);
    apb(1'b1, 12'h000, 32'h0);
    repeat (4) @(posedge CLOCK);
    summarize();
  end
endmodule : usr_shift_register_bench
`default_nettype wire
